// *** dv/cfm_contacts.sv ***
// forced-guided feedback contacts model for the contact feedback monitor
module cfm_contacts #(
   parameter int unsigned LAG  = 3,
   parameter int unsigned SLOW = 40
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic drive,
   input  wire logic weld,
   input  wire logic slow_b,
   output logic      fb_a,
   output logic      fb_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       drv_r;
   logic [7:0] age_r;
   logic       a_r;
   logic       b_r;
   // normally closed contacts open after the coil pulls in, close after release
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drv_r <= 1'b0;
         age_r <= 8'h00;
         a_r   <= 1'b1;
         b_r   <= 1'b1;
      end else begin
         if (drive != drv_r) begin
            drv_r <= drive;
            age_r <= 8'h00;
         end else if (age_r != 8'hff) begin
            age_r <= age_r + 8'h01;
         end
         if (age_r == 8'(LAG)) a_r <= ~drv_r;
         if (age_r == 8'(slow_b ? SLOW : LAG)) b_r <= ~drv_r;
      end
   end
   // a welded channel stays open whatever the coil does
   assign fb_a = a_r & ~weld;
   assign fb_b = b_r;
endmodule : cfm_contacts

// *** dv/cfm_top_tb.sv ***
// self-checking bench for the contact feedback monitor
module cfm_top_tb
   import cfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, arst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        wait_s, fa, fbi, pb, fbo, fboe, soa, sob, erst, efo, fl;
   logic        beam = 1'b1, rtest = 1'b1, rsw = 1'b0, elock = 1'b0;
   logic        weld = 1'b0, slow = 1'b0;
   int          n_fail = 0, checks_done = 0, cyc = 0, n_er = 0;
   // short windows keep the run brief: 20 window, 10..40 press
   cfm_top #(.WIN_CYC(20), .RMIN_CYC(10), .RMAX_CYC(40)) cfm_top_inst (
      .clk(clk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_s), .feedback_input_a(fa), .feedback_input_b_in(fbi),
      .feedback_input_b_out(fbo), .feedback_input_b_oe(fboe), .beam_clear(beam),
      .remote_test_closed(rtest), .reset_switch_closed(rsw),
      .emitter_lockout(elock), .safety_output_a(soa), .safety_output_b(sob),
      .emitter_reset(erst), .emitter_fault_out(efo), .fault_line(fl));
   cfm_contacts cfm_contacts_inst (.clk(clk), .arst_n(arst_n), .drive(soa),
      .weld(weld), .slow_b(slow), .fb_a(fa), .fb_b(pb));
   // line b carries the aux output whenever the block drives it
   assign fbi = fboe ? fbo : pb;
   always #5 clk = ~clk;
   // hang guard and emitter reset pulse count
   always @(posedge clk) begin
      cyc++;
      if (erst === 1'b1) n_er++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_s  <= 1'b1;
      do @(posedge clk); while (wait_s !== 1'b0);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      do @(posedge clk); while (wait_s !== 1'b0);
      v = rdata;
      rd_s <= 1'b0;
   endtask : rd
   task automatic st(input logic [31:0] exp);
      rd(OFS_STATUS, d);
      chk(d & 32'h3, exp);
   endtask : st
   // hold the switch closed n cycles, then open it
   task automatic press(input int n);
      @(posedge clk);
      rsw <= 1'b1;
      repeat (n) @(posedge clk);
      rsw <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : press
   task automatic rst();
      @(posedge clk);
      arst_n <= 1'b0;
      beam   <= 1'b1;
      rtest  <= 1'b1;
      weld   <= 1'b0;
      slow   <= 1'b0;
      elock  <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
   endtask : rst
   task automatic t_def();
      rst();
      rd(OFS_CTRL, d);
      chk(d, 32'h0);
      st(32'h0);
      rd(4'h8, d);
      chk(d, 32'h0);
      // writes to the status word must leave the configuration alone
      wr(OFS_STATUS, 32'h3f);
      rd(OFS_CTRL, d);
      chk(d, 32'h0);
      press(5);
      chk(32'(soa), 32'h0);
      weld <= 1'b1;
      press(12);
      chk(32'(soa | sob), 32'h0);
      // channel a held open alone: dual lockout naming channel a
      repeat (10) @(posedge clk);
      rd(OFS_STATUS, d);
      chk(d, 32'h6a);
      $display("test defaults done");
   endtask : t_def
   task automatic t_dual();
      rst();
      press(15);
      st(32'h1);
      repeat (50) @(posedge clk);
      st(32'h1);
      rtest <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(soa | sob), 32'h0);
      rtest <= 1'b1;
      repeat (10) @(posedge clk);
      press(15);
      wr(OFS_CTRL, 32'h20);
      slow <= 1'b1;
      beam <= 1'b0;
      repeat (60) @(posedge clk);
      st(32'h2);
      rd(OFS_STATUS, d);
      chk(d & 32'hf0, 32'ha0);
      chk(32'(fl), 32'h1);
      beam <= 1'b1;
      slow <= 1'b0;
      press(15);
      st(32'h0);
      press(15);
      st(32'h1);
      $display("test dual done");
   endtask : t_dual
   task automatic t_single();
      rst();
      wr(OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(fboe), 32'h1);
      rd(OFS_CTRL, d);
      chk(d, 32'h1);
      press(15);
      st(32'h1);
      chk(32'(fbo), 32'h1);
      repeat (50) @(posedge clk);
      st(32'h1);
      // contacts close in time after turn-off: no lockout
      beam <= 1'b0;
      repeat (40) @(posedge clk);
      st(32'h0);
      beam <= 1'b1;
      press(15);
      wr(OFS_CTRL, 32'h5);
      weld <= 1'b1;
      beam <= 1'b0;
      repeat (50) @(posedge clk);
      st(32'h2);
      rd(OFS_STATUS, d);
      chk(d & 32'h10, 32'h10);
      chk(32'(fbo), 32'h1);
      $display("test single done");
   endtask : t_single
   // mismatching channels never lock when checking is off
   task automatic t_none();
      rst();
      wr(OFS_CTRL, 32'h2);
      slow <= 1'b1;
      press(15);
      repeat (60) @(posedge clk);
      st(32'h1);
      beam <= 1'b0;
      repeat (60) @(posedge clk);
      st(32'h0);
      $display("test none done");
   endtask : t_none
   task automatic t_par();
      rst();
      wr(OFS_CTRL, 32'h18);
      n_er = 0;
      press(15);
      chk(32'(n_er), 32'h1);
      rtest <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'({soa, sob}), 32'h3);
      elock <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(efo), 32'h1);
      $display("test parallel done");
   endtask : t_par
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      t_def();
      t_dual();
      t_single();
      t_none();
      t_par();
      results();
   end
endmodule : cfm_top_tb

// *** hw/cfm_pkg.sv ***
// constants shared by the contact feedback monitor files
package cfm_pkg;
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned WINDOW_MS     = 250;
   localparam int unsigned WINDOW_CYC    = WINDOW_MS * CYC_PER_MS;
   localparam int unsigned RST_MIN_MS    = 250;
   localparam int unsigned RST_MAX_MS    = 2000;
   localparam int unsigned RST_MIN_CYC   = RST_MIN_MS * CYC_PER_MS;
   localparam int unsigned RST_MAX_CYC   = RST_MAX_MS * CYC_PER_MS;
   // register byte offsets
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_STATUS    = 4'h4;
   // control fields
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_AUXF_BIT = 2;
   localparam int unsigned CTRL_EMFE_BIT = 3;
   localparam int unsigned CTRL_PAR_BIT  = 4;
   localparam int unsigned CTRL_COMB_BIT = 5;
   localparam logic [1:0]  MODE_DUAL     = 2'h0;
   localparam logic [1:0]  MODE_SINGLE   = 2'h1;
   localparam logic [1:0]  MODE_NONE     = 2'h2;
   localparam logic [5:0]  CTRL_RESET    = 6'h00;
   typedef enum logic [1:0] {CFM_OFF, CFM_ON, CFM_LOCK} cfm_state_t;
endpackage : cfm_pkg

// *** hw/cfm_reset_qual.sv ***
// turns a closed-then-opened reset switch into a one-cycle request
module cfm_reset_qual
   import cfm_pkg::*;
#(
   parameter int unsigned MIN_CYC = RST_MIN_CYC,
   parameter int unsigned MAX_CYC = RST_MAX_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic switch_closed,
   output logic      reset_req
);
   logic [31:0] held_r;
   logic        closed_d_r;

   // measure closed time, saturating so a stuck switch never wraps
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         held_r     <= 32'h0;
         closed_d_r <= 1'b0;
      end else begin
         closed_d_r <= switch_closed;
         if (!switch_closed) begin
            held_r <= 32'h0;
         end else if (held_r <= MAX_CYC) begin
            held_r <= held_r + 32'h1;
         end
      end
   end

   // request only on release, and only for a press of legal length
   assign reset_req = closed_d_r && !switch_closed &&
                      (held_r >= MIN_CYC) && (held_r <= MAX_CYC);
endmodule : cfm_reset_qual

// *** hw/cfm_tmr_if.sv ***
// window timer hookup between monitor and timer
interface cfm_tmr_if;
   logic run;
   logic expired;
   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface : cfm_tmr_if

// *** hw/cfm_top.sv ***
// contact feedback monitor: reset gating, window checks, lockout, aux and fault lines
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
module cfm_top
   import cfm_pkg::*;
#(
   parameter int unsigned WIN_CYC  = WINDOW_CYC,
   parameter int unsigned RMIN_CYC = RST_MIN_CYC,
   parameter int unsigned RMAX_CYC = RST_MAX_CYC
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        feedback_input_a,
   input  wire logic        feedback_input_b_in,
   output logic             feedback_input_b_out,
   output logic             feedback_input_b_oe,
   input  wire logic        beam_clear,
   input  wire logic        remote_test_closed,
   input  wire logic        reset_switch_closed,
   input  wire logic        emitter_lockout,
   output logic             safety_output_a,
   output logic             safety_output_b,
   output logic             emitter_reset,
   output logic             emitter_fault_out,
   output logic             fault_line
);
   cfm_state_t  state_r;
   cfm_state_t  state_nxt;
   logic [5:0]  ctrl_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic        pend_r;
   logic        cause_single_r;
   logic        cause_dual_r;
   logic        diag_a_r;
   logic        diag_b_r;
   logic        b_oe_r;
   logic        b_out_r;
   logic        so_a_r;
   logic        so_b_r;
   logic        em_rst_r;
   logic        em_fault_r;
   logic        fault_r;
   logic        reset_req;
   logic [1:0]  mode;
   logic        fb_ok;
   logic        fb_b;
   logic        run_ok;
   cfm_tmr_if   tmr ();

   assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
   // line b is an output in single mode, so its input is meaningless there
   assign fb_b = (mode == MODE_SINGLE) ? 1'b1 : feedback_input_b_in;

   // feedback closed for the selected mode
   always_comb begin
      case (mode)
         MODE_DUAL:   fb_ok = feedback_input_a && feedback_input_b_in;
         MODE_SINGLE: fb_ok = feedback_input_a;
         default:     fb_ok = 1'b1;
      endcase
   end

   // test input is dead when the emitter shares the receiver cable
   assign run_ok = beam_clear && (remote_test_closed || ctrl_r[CTRL_PAR_BIT]);

   cfm_reset_qual #(
      .MIN_CYC (RMIN_CYC),
      .MAX_CYC (RMAX_CYC)
   ) u_rq (
      .clk           (clk),
      .arst_n        (arst_n),
      .switch_closed (reset_switch_closed),
      .reset_req     (reset_req)
   );

   cfm_window_timer #(
      .LIMIT (WIN_CYC)
   ) u_tmr (
      .clk    (clk),
      .arst_n (arst_n),
      .t      (tmr)
   );

   // single: open after turn-off; dual: channels disagree
   always_comb begin
      case (mode)
         MODE_SINGLE: tmr.run = pend_r && !feedback_input_a;
         MODE_DUAL:   tmr.run = feedback_input_a ^ feedback_input_b_in;
         default:     tmr.run = 1'b0;
      endcase
   end

   // main sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CFM_OFF: begin
            if (tmr.expired) begin
               state_nxt = CFM_LOCK;
            end else if (reset_req && fb_ok && run_ok) begin
               state_nxt = CFM_ON;
            end
         end
         CFM_ON: begin
            if (tmr.expired) begin
               state_nxt = CFM_LOCK;
            end else if (!run_ok) begin
               state_nxt = CFM_OFF;
            end
         end
         CFM_LOCK: begin
            if (reset_req && fb_ok && !tmr.run) begin
               state_nxt = CFM_OFF;
            end
         end
         default: state_nxt = CFM_LOCK;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= CFM_OFF;
         so_a_r  <= 1'b0;
         so_b_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         so_a_r  <= (state_nxt == CFM_ON);
         so_b_r  <= (state_nxt == CFM_ON);
      end
   end

   // single mode: closure owed after every on-to-off change
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_r <= 1'b0;
      end else if (state_r == CFM_ON && state_nxt != CFM_ON) begin
         pend_r <= 1'b1;
      end else if (feedback_input_a || state_r == CFM_LOCK) begin
         pend_r <= 1'b0;
      end
   end

   // lockout cause and per-channel diagnostics, kept until lockout clears
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cause_single_r <= 1'b0;
         cause_dual_r   <= 1'b0;
         diag_a_r       <= 1'b0;
         diag_b_r       <= 1'b0;
      end else if (tmr.expired && state_r != CFM_LOCK) begin
         cause_single_r <= (mode == MODE_SINGLE);
         cause_dual_r   <= (mode == MODE_DUAL);
         diag_a_r       <= (mode == MODE_DUAL) && !feedback_input_a;
         diag_b_r       <= (mode == MODE_DUAL) && !feedback_input_b_in;
      end else if (state_r == CFM_LOCK && state_nxt == CFM_OFF) begin
         cause_single_r <= 1'b0;
         cause_dual_r   <= 1'b0;
         diag_a_r       <= 1'b0;
         diag_b_r       <= 1'b0;
      end
   end

   // aux, emitter and shared fault lines
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         b_oe_r     <= 1'b0;
         b_out_r    <= 1'b0;
         em_rst_r   <= 1'b0;
         em_fault_r <= 1'b0;
         fault_r    <= 1'b0;
      end else begin
         b_oe_r     <= (mode == MODE_SINGLE);
         b_out_r    <= ctrl_r[CTRL_AUXF_BIT] ? (state_r == CFM_LOCK)
                                             : (state_r == CFM_ON);
         em_rst_r   <= reset_req && ctrl_r[CTRL_PAR_BIT];
         em_fault_r <= ctrl_r[CTRL_EMFE_BIT] && emitter_lockout;
         fault_r    <= ctrl_r[CTRL_COMB_BIT] &&
                       (emitter_lockout || state_r == CFM_LOCK);
      end
   end

   // avalon slave: fixed one wait cycle, answer on the following edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
         ctrl_r  <= CTRL_RESET;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         if (avs_read && wait_r) begin
            case (avs_address)
               OFS_CTRL:   rdata_r <= {26'h0, ctrl_r};
               OFS_STATUS: rdata_r <= {24'h0, diag_b_r, diag_a_r, cause_dual_r,
                                       cause_single_r, fb_b, feedback_input_a,
                                       state_r};
               default:    rdata_r <= 32'h0;
            endcase
         end
         if (avs_write && !wait_r && avs_address == OFS_CTRL) begin
            ctrl_r <= avs_writedata[5:0];
         end
      end
   end

   assign avs_readdata         = rdata_r;
   assign avs_waitrequest      = wait_r;
   assign feedback_input_b_out = b_out_r;
   assign feedback_input_b_oe  = b_oe_r;
   assign safety_output_a      = so_a_r;
   assign safety_output_b      = so_b_r;
   assign emitter_reset        = em_rst_r;
   assign emitter_fault_out    = em_fault_r;
   assign fault_line           = fault_r;

   // checks
   sequence s_off_req_bad;
      state_r == CFM_OFF && reset_req && !fb_ok;
   endsequence
   // running with beams clear, whatever the feedback shows
   sequence s_on_stable;
      state_r == CFM_ON && run_ok;
   endsequence

   property p_reset_gate;
      @(posedge clk) disable iff (!arst_n) s_off_req_bad |=> !safety_output_a;
   endproperty
   a_reset_gate: assert property (p_reset_gate) else $error("reset taken with open feedback");

   property p_single_ignore;
      @(posedge clk) disable iff (!arst_n)
         (mode == MODE_SINGLE) and s_on_stable |=> safety_output_a && safety_output_b;
   endproperty
   a_single_ignore: assert property (p_single_ignore) else $error("single mode dropped on feedback");

   property p_expire_lock;
      @(posedge clk) disable iff (!arst_n)
         tmr.expired |=> state_r == CFM_LOCK ##1 !safety_output_a;
   endproperty
   a_expire_lock: assert property (p_expire_lock) else $error("window expiry without lockout");

   property p_dual_together;
      @(posedge clk) disable iff (!arst_n)
         (mode == MODE_DUAL && feedback_input_a == feedback_input_b_in) and s_on_stable
            |=> state_r == CFM_ON;
   endproperty
   a_dual_together: assert property (p_dual_together) else $error("agreeing channels caused stop");

   property p_test_off;
      @(posedge clk) disable iff (!arst_n)
         !remote_test_closed && !ctrl_r[CTRL_PAR_BIT] |-> ##1 !safety_output_a ##0 !safety_output_b;
   endproperty
   a_test_off: assert property (p_test_off) else $error("outputs on with test open");

   property p_aux_pin;
      @(posedge clk) disable iff (!arst_n)
         ##1 feedback_input_b_oe == ($past(mode) == MODE_SINGLE);
   endproperty
   a_aux_pin: assert property (p_aux_pin) else $error("aux drive wrong for mode");

   property p_aux_follow;
      @(posedge clk) disable iff (!arst_n)
         !ctrl_r[CTRL_AUXF_BIT] && $stable(ctrl_r) |=>
            feedback_input_b_out == ($past(state_r) == CFM_ON);
   endproperty
   a_aux_follow: assert property (p_aux_follow) else $error("aux not following outputs");

   property p_emit_reset;
      @(posedge clk) disable iff (!arst_n)
         reset_req && ctrl_r[CTRL_PAR_BIT] |=> emitter_reset ##1 !emitter_reset;
   endproperty
   a_emit_reset: assert property (p_emit_reset) else $error("emitter not reset with receiver");

   property p_comb_fault;
      @(posedge clk) disable iff (!arst_n)
         ctrl_r[CTRL_COMB_BIT] && state_r == CFM_LOCK |=> fault_line;
   endproperty
   a_comb_fault: assert property (p_comb_fault) else $error("shared fault missing lockout");
endmodule : cfm_top

// *** hw/cfm_window_timer.sv ***
// counts a continuous condition against a window length
module cfm_window_timer
   import cfm_pkg::*;
#(
   parameter int unsigned LIMIT = WINDOW_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   cfm_tmr_if.timer  t
);
   logic [31:0] cnt_r;

   // restart whenever the condition drops; saturate past the limit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 32'h0;
      end else if (!t.run) begin
         cnt_r <= 32'h0;
      end else if (cnt_r <= LIMIT) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // strictly longer than the window
   assign t.expired = t.run && (cnt_r > LIMIT);
endmodule : cfm_window_timer
